// >>> dv/sdmr_ctrl_model.sv
// controller-side model that drives commands and the clock gate
`timescale 1ns/1ps
module sdmr_ctrl_model (
  input  wire logic        i_clk,
  output logic             o_cke,
  output logic             o_cs_n,
  output logic [2:0]       o_cmd,
  output logic [1:0]       o_bs,
  output logic [11:0]      o_addr
);
  initial begin
    {o_cke, o_cs_n, o_cmd, o_bs, o_addr} = {1'b1, 1'b1, 3'h7, 2'h0, 12'h000};
  end
  // one selected command, sampled at the next edge only
  task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a, input logic g = 1'b1);
    @(posedge i_clk);
    {o_cke, o_cs_n, o_cmd, o_bs, o_addr} <= {g, 1'b0, c, b, a};
  endtask
  // deselected: strobes and address churn so a stale value never passes
  task automatic desel(input logic g = 1'b1);
    @(posedge i_clk);
    {o_cke, o_cs_n, o_cmd, o_bs, o_addr} <= {g, 1'b1, 17'($urandom)};
  endtask
  // test bits always normal, latency written as given, reserved codes included
  task automatic mrs(input logic [2:0] bl, input logic bt, input logic [2:0] cl, input logic wb);
    issue(sdmr_pkg::CMD_MRS, 2'h0, {2'h0, wb, sdmr_pkg::TM_NORMAL, cl, bt, bl});
  endtask
  // deselects with the clock gate held low
  task automatic hold_low(input int n);
    repeat (n) desel(1'b0);
  endtask
endmodule

// >>> dv/sdram_mode_and_refresh_cmds_tb.sv
// self-checking bench for the mode decode, burst sequencer and refresh states
`timescale 1ns/1ps
module sdram_mode_and_refresh_cmds_tb;
  logic        clk;
  logic        srst;
  logic        cke;
  logic        cs_n;
  logic [2:0]  cmd;
  logic [1:0]  bs;
  logic [11:0] addr;
  logic [7:0]  col_addr;
  logic [3:0]  burst_len;
  logic [1:0]  rlat;
  logic [11:0] ref_row;
  logic [3:0]  banks;
  logic        col_valid, col_write, rd_drive, full_page, interleave, lat_res;
  logic        test_mode, single_wr, ref_pulse, sref, pdown, csusp;
  logic [2:0]  m_bl, m_cl;
  logic        m_bt, m_wb;
  logic [11:0] row;
  logic [7:0]  c0;
  logic [1:0]  bk;
  logic        last_wr;
  // row cycle time of the slower grade, in clocks
  localparam int ROW_CYCLE = 18;
  logic [2:0]  bls [5] = '{sdmr_pkg::BL_1, sdmr_pkg::BL_2, sdmr_pkg::BL_4, sdmr_pkg::BL_8, sdmr_pkg::BL_PAGE};
  int          err_total;
  int          n_compared;

  sdmr_ctrl_model model (.i_clk(clk), .o_cke(cke), .o_cs_n(cs_n), .o_cmd(cmd), .o_bs(bs), .o_addr(addr));
  sdmr_core uut (.i_clk(clk), .i_srst(srst), .i_cke(cke), .i_cs_n(cs_n), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]),
    .i_we_n(cmd[0]), .i_bs(bs), .i_addr(addr), .o_col_addr(col_addr), .o_col_valid(col_valid),
    .o_col_write(col_write), .o_rd_drive(rd_drive), .o_burst_len(burst_len), .o_full_page(full_page),
    .o_interleave(interleave), .o_read_latency(rlat), .o_latency_reserved(lat_res), .o_test_mode(test_mode),
    .o_single_write(single_wr), .o_refresh_pulse(ref_pulse), .o_refresh_row(ref_row), .o_self_refresh(sref),
    .o_power_down(pdown), .o_clk_suspend(csusp), .o_banks_active(banks));

  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // page length stands in as a count far beyond any run
  function automatic int f_len(input logic [2:0] b);
    case (b)
      sdmr_pkg::BL_2:    return 2;
      sdmr_pkg::BL_4:    return 4;
      sdmr_pkg::BL_8:    return 8;
      sdmr_pkg::BL_PAGE: return 1000;
      default:           return 1;
    endcase
  endfunction
  // single-write mode shows one word while the last burst was a write
  function automatic logic [11:0] f_blen(input logic [2:0] b);
    if (m_wb && last_wr) return 12'h001;
    return (b == sdmr_pkg::BL_PAGE) ? 12'h000 : 12'(f_len(b));
  endfunction
  function automatic logic [7:0] f_col(input logic [7:0] st, input int k);
    if (m_bt && m_bl inside {sdmr_pkg::BL_2, sdmr_pkg::BL_4, sdmr_pkg::BL_8}) begin
      return st ^ (8'(k) & 8'(f_len(m_bl) - 1));
    end
    return st + 8'(k);
  endfunction
  task automatic set_mode(input logic [2:0] bl, input logic bt, input logic [2:0] cl, input logic wb);
    {m_bl, m_bt, m_cl, m_wb} = {bl, bt, cl, wb};
    model.mrs(bl, bt, cl, wb);
    model.desel();
    @(negedge clk);
    chk("burst_len", f_blen(bl), 12'(burst_len));
    chk("full_page", 12'(bl == sdmr_pkg::BL_PAGE), 12'(full_page));
    chk("interleave", 12'(bt), 12'(interleave));
    chk("read_latency", 12'(cl[1:0]), 12'(rlat));
    chk("latency_reserved", 12'(cl != sdmr_pkg::CL_2 && cl != sdmr_pkg::CL_3), 12'(lat_res));
    chk("single_write", 12'(wb), 12'(single_wr));
    chk("test_mode", 12'h000, 12'(test_mode));
  endtask
  // s: cycle in which a burst stop is driven, 0 for none
  task automatic burst(input logic [2:0] c, input logic [7:0] st, input logic ap, input int s);
    int lw;
    int w;
    lw = (c == sdmr_pkg::CMD_WRITE && m_wb) ? 1 : f_len(m_bl);
    w = (s != 0 && !ap && s < lw) ? s : lw;
    last_wr = (c == sdmr_pkg::CMD_WRITE);
    model.issue(c, 2'($urandom), {1'($urandom), ap, 2'($urandom), st});
    for (int j = 1; j <= w + 4; j++) begin
      if (j == s) model.issue(sdmr_pkg::CMD_STOP, 2'($urandom), 12'($urandom) & 12'hBFF);
      else if (j % 2 == 1) model.desel();
      else model.issue(sdmr_pkg::CMD_IDLE, 2'($urandom), 12'($urandom));
      @(negedge clk);
      chk("col_valid", 12'(j <= w), 12'(col_valid));
      if (j <= w) chk("col_addr", 12'(f_col(st, j - 1)), 12'(col_addr));
      if (j <= w) chk("col_write", 12'(c == sdmr_pkg::CMD_WRITE), 12'(col_write));
      chk("rd_drive", 12'(c == sdmr_pkg::CMD_READ && j > m_cl && j <= w + m_cl), 12'(rd_drive));
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #400000;
    err_total++;
    test_done();
  end
  initial begin
    err_total = 0;
    n_compared = 0;
    srst = 1'b1;
    row = 12'h000;
    last_wr = 1'b0;
    void'($urandom(29987));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("burst_len", 12'h001, 12'(burst_len));
    chk("latency_reserved", 12'h001, 12'(lat_res));
    set_mode(sdmr_pkg::BL_PAGE, 1'b1, sdmr_pkg::CL_3, 1'b0);
    burst(sdmr_pkg::CMD_READ, 8'hFB, 1'b0, 262);
    set_mode(sdmr_pkg::BL_8, 1'b1, sdmr_pkg::CL_2, 1'b0);
    burst(sdmr_pkg::CMD_READ, 8'h35, 1'b1, 3);
    set_mode(sdmr_pkg::BL_4, 1'b0, sdmr_pkg::CL_2, 1'b1);
    burst(sdmr_pkg::CMD_WRITE, 8'hFE, 1'b0, 0);
    burst(sdmr_pkg::CMD_READ, 8'hFE, 1'b0, 0);
    set_mode(3'h5, 1'b0, 3'h4, 1'b0);
    burst(sdmr_pkg::CMD_WRITE, 8'h12, 1'b0, 0);
    for (int i = 0; i < 20; i++) begin
      set_mode(bls[i % 5], 1'($urandom), $urandom_range(1) ? sdmr_pkg::CL_3 : sdmr_pkg::CL_2, 1'($urandom));
      burst($urandom_range(1) ? sdmr_pkg::CMD_READ : sdmr_pkg::CMD_WRITE, 8'($urandom), 1'b0,
        (i % 5 == 4) ? $urandom_range(20, 1) : $urandom_range(9));
    end
    bk = 2'($urandom);
    model.issue(sdmr_pkg::CMD_ACT, bk, 12'($urandom));
    model.mrs(3'($urandom), 1'($urandom), 3'($urandom), 1'($urandom));
    model.desel();
    @(negedge clk);
    chk("banks_active", 12'(4'h1) << bk, 12'(banks));
    chk("burst_len", f_blen(m_bl), 12'(burst_len));
    model.hold_low(2);
    @(negedge clk);
    chk("clk_suspend", 12'h001, 12'(csusp));
    model.desel();
    model.issue(sdmr_pkg::CMD_PRE, 2'($urandom), 12'($urandom) | 12'h400);
    model.desel();
    @(negedge clk);
    chk("banks_active", 12'h000, 12'(banks));
    for (int i = 0; i < 3; i++) begin
      model.issue(sdmr_pkg::CMD_REF, 2'($urandom), 12'($urandom));
      model.desel();
      @(negedge clk);
      row = row + 12'h001;
      chk("refresh_pulse", 12'h001, 12'(ref_pulse));
      chk("refresh_row", row, ref_row);
      model.desel();
      @(negedge clk);
      chk("refresh_pulse", 12'h000, 12'(ref_pulse));
      repeat (ROW_CYCLE) model.desel();
    end
    model.issue(sdmr_pkg::CMD_REF, 2'($urandom), 12'($urandom), 1'b0);
    // anything selected while self refreshing must be ignored
    repeat (2) model.issue(3'($urandom), 2'($urandom), 12'($urandom), 1'b0);
    @(negedge clk);
    chk("self_refresh", 12'h001, 12'(sref));
    chk("refresh_row", row, ref_row);
    chk("col_valid", 12'h000, 12'(col_valid));
    repeat (2) model.desel();
    @(negedge clk);
    chk("self_refresh", 12'h000, 12'(sref));
    repeat (ROW_CYCLE) model.desel();
    model.hold_low(2);
    @(negedge clk);
    chk("power_down", 12'h001, 12'(pdown));
    repeat (2) model.desel();
    @(negedge clk);
    chk("power_down", 12'h000, 12'(pdown));
    set_mode(sdmr_pkg::BL_PAGE, 1'b0, sdmr_pkg::CL_2, 1'b0);
    c0 = 8'($urandom);
    model.issue(sdmr_pkg::CMD_READ, 2'($urandom), {1'($urandom), 1'b0, 2'($urandom), c0});
    repeat (3) model.desel();
    model.hold_low(2);
    @(negedge clk);
    chk("col_addr", 12'(8'(c0 + 8'h04)), 12'(col_addr));
    c0 = col_addr;
    chk("clk_suspend", 12'h001, 12'(csusp));
    model.hold_low(2);
    @(negedge clk);
    chk("col_addr", 12'(c0), 12'(col_addr));
    repeat (2) model.desel();
    @(negedge clk);
    chk("clk_suspend", 12'h000, 12'(csusp));
    chk("col_valid", 12'h001, 12'(col_valid));
    model.issue(sdmr_pkg::CMD_STOP, 2'($urandom), 12'($urandom));
    repeat (4) model.desel();
    @(negedge clk);
    chk("col_valid", 12'h000, 12'(col_valid));
    test_done();
  end
endmodule

// >>> hw/sdmr_core.sv
// mode register, burst column sequencer, refresh and clock-gate power states
// Summary of operation
// - low three mode bits select burst length 1,2,4,8 or full page
// - mode bit 3 picks sequential or interleaved column ordering
// - sequential bursts add word index to start column, wrapping in 8 bits
// - full-page burst cycles through the page until another command ends it
// - interleaved column is start xor word index over 1, 2 or 3 bits
// - mode bits 6..4 give read latency: 010 two clocks, 011 three
// - mode bit 9 set makes every write a single word
// - selected with all strobes high is an idle command, nothing happens
// - burst stop ends a burst unless it was started with auto precharge
// - after burst stop read data keeps flowing for the read latency
// - chip select high ignores strobes and address entirely
// - auto refresh refreshes the internal row counter and advances it
// - refresh with clock gate low enters self refresh, only gate watched
// - gate low during a burst freezes operation from the next cycle
// - gate low with all banks idle and no burst or read data pending enters power-down
// - mode register set loads bank select and address in one clock, only with all banks idle and no burst
// - gate high resumes clock or leaves power-down for the next cycle
`timescale 1ns/1ps
module sdmr_core (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_cke,
  input  wire logic        i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic [1:0]  i_bs,
  input  wire logic [11:0] i_addr,
  output logic      [7:0]  o_col_addr,
  output logic             o_col_valid,
  output logic             o_col_write,
  output logic             o_rd_drive,
  output logic      [3:0]  o_burst_len,
  output logic             o_full_page,
  output logic             o_interleave,
  output logic      [1:0]  o_read_latency,
  output logic             o_latency_reserved,
  output logic             o_test_mode,
  output logic             o_single_write,
  output logic             o_refresh_pulse,
  output logic      [11:0] o_refresh_row,
  output logic             o_self_refresh,
  output logic             o_power_down,
  output logic             o_clk_suspend,
  output logic      [3:0]  o_banks_active
);
  sdmr_pkg::sdmr_pwr_t pwr_reg, pwr_next;
  logic [13:0] mode_reg, mode_next;
  logic [3:0]  bank_reg, bank_next;
  logic        valid_reg, valid_next;
  logic        wr_reg, wr_next;
  logic        ap_reg, ap_next;
  logic [7:0]  start_reg, start_next;
  logic [7:0]  k_reg, k_next;
  logic [7:0]  col_reg, col_next;
  logic [2:0]  pipe_reg, pipe_next;
  logic [11:0] row_reg, row_next;
  logic        rpulse_reg, rpulse_next;

  logic [2:0] cmd;
  logic       run;
  logic       sel;
  logic [2:0] bl_code;
  logic [2:0] cl_code;
  logic       page;
  logic [7:0] last_k;
  logic [7:0] imask;
  logic       last;
  logic       adv;

  assign cmd     = {i_ras_n, i_cas_n, i_we_n};
  assign run     = (pwr_reg == sdmr_pkg::SDMR_RUN);
  assign sel     = run && !i_cs_n;
  assign bl_code = mode_reg[sdmr_pkg::BL_LSB +: 3];
  assign cl_code = mode_reg[sdmr_pkg::CL_LSB +: 3];
  assign page    = (bl_code == sdmr_pkg::BL_PAGE) && !(wr_reg && mode_reg[sdmr_pkg::WB_POS]);
  assign last    = !page && (k_reg == last_k);
  assign adv     = run && valid_reg && !last;

  // last word index and interleave mask from the length code
  always_comb begin
    last_k = 8'h00;
    imask  = 8'h00;
    unique case (bl_code)
      sdmr_pkg::BL_2:    begin last_k = 8'h01; imask = 8'h01; end
      sdmr_pkg::BL_4:    begin last_k = 8'h03; imask = 8'h03; end
      sdmr_pkg::BL_8:    begin last_k = 8'h07; imask = 8'h07; end
      sdmr_pkg::BL_PAGE: begin last_k = 8'hFF; imask = 8'h00; end
      default:           begin last_k = 8'h00; imask = 8'h00; end
    endcase
    if (wr_reg && mode_reg[sdmr_pkg::WB_POS]) begin
      last_k = 8'h00;
    end
  end

  always_comb begin
    pwr_next    = pwr_reg;
    mode_next   = mode_reg;
    bank_next   = bank_reg;
    valid_next  = valid_reg;
    wr_next     = wr_reg;
    ap_next     = ap_reg;
    start_next  = start_reg;
    k_next      = k_reg;
    col_next    = col_reg;
    pipe_next   = pipe_reg;
    row_next    = row_reg;
    rpulse_next = 1'b0;
    if (run) begin
      // read data lags its column by the latency, even after a stop
      pipe_next = {pipe_reg[1:0], valid_reg && !wr_reg};
      if (adv) begin
        k_next = k_reg + 8'h01;
        if (mode_reg[sdmr_pkg::BT_POS] && !page) begin
          col_next = start_reg ^ ((k_reg + 8'h01) & imask);
        end else begin
          col_next = start_reg + k_reg + 8'h01;
        end
      end else begin
        valid_next = 1'b0;
      end
      if (sel) begin
        unique case (cmd)
          sdmr_pkg::CMD_MRS: begin
            if (bank_reg == sdmr_pkg::BANK_RESET && !valid_reg) begin
              mode_next = {i_bs, i_addr};
            end
          end
          sdmr_pkg::CMD_ACT: begin
            bank_next[i_bs] = 1'b1;
          end
          sdmr_pkg::CMD_PRE: begin
            if (i_addr[sdmr_pkg::AP_POS]) begin
              bank_next = sdmr_pkg::BANK_RESET;
            end else begin
              bank_next[i_bs] = 1'b0;
            end
          end
          sdmr_pkg::CMD_REF: begin
            if (i_cke) begin
              row_next    = row_reg + 12'h001;
              rpulse_next = 1'b1;
            end
          end
          sdmr_pkg::CMD_READ, sdmr_pkg::CMD_WRITE: begin
            valid_next = 1'b1;
            wr_next    = !i_we_n;
            ap_next    = i_addr[sdmr_pkg::AP_POS];
            start_next = i_addr[7:0];
            col_next   = i_addr[7:0];
            k_next     = 8'h00;
          end
          sdmr_pkg::CMD_STOP: begin
            if (!ap_reg) begin
              valid_next = 1'b0;
            end
          end
          sdmr_pkg::CMD_IDLE: begin
          end
        endcase
      end
      if (!i_cke) begin
        if (sel && cmd == sdmr_pkg::CMD_REF) begin
          pwr_next = sdmr_pkg::SDMR_SREF;
        end else if (valid_next || pipe_next != sdmr_pkg::PIPE_RESET
                     || bank_next != sdmr_pkg::BANK_RESET) begin
          pwr_next = sdmr_pkg::SDMR_SUSPEND;
        end else begin
          pwr_next = sdmr_pkg::SDMR_PDOWN;
        end
      end
    end else if (i_cke) begin
      // frozen state resumes one clock after the gate is seen high
      pwr_next = sdmr_pkg::SDMR_RUN;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pwr_reg    <= sdmr_pkg::SDMR_RUN;
      mode_reg   <= sdmr_pkg::MODE_RESET;
      bank_reg   <= sdmr_pkg::BANK_RESET;
      valid_reg  <= 1'b0;
      wr_reg     <= 1'b0;
      ap_reg     <= 1'b0;
      start_reg  <= sdmr_pkg::COL_RESET;
      k_reg      <= 8'h00;
      col_reg    <= sdmr_pkg::COL_RESET;
      pipe_reg   <= sdmr_pkg::PIPE_RESET;
      row_reg    <= sdmr_pkg::REF_ROW_RESET;
      rpulse_reg <= 1'b0;
    end else begin
      pwr_reg    <= pwr_next;
      mode_reg   <= mode_next;
      bank_reg   <= bank_next;
      valid_reg  <= valid_next;
      wr_reg     <= wr_next;
      ap_reg     <= ap_next;
      start_reg  <= start_next;
      k_reg      <= k_next;
      col_reg    <= col_next;
      pipe_reg   <= pipe_next;
      row_reg    <= row_next;
      rpulse_reg <= rpulse_next;
    end
  end

  assign o_col_addr         = col_reg;
  assign o_col_valid        = valid_reg;
  assign o_col_write        = wr_reg;
  assign o_rd_drive         = (cl_code == sdmr_pkg::CL_3) ? pipe_reg[2] : pipe_reg[1];
  assign o_burst_len        = last_k[3:0] + 4'h1;
  assign o_full_page        = (bl_code == sdmr_pkg::BL_PAGE);
  assign o_interleave       = mode_reg[sdmr_pkg::BT_POS];
  assign o_read_latency     = cl_code[1:0];
  // reserved codes fall back to two clocks; behaviour is undefined anyway
  assign o_latency_reserved = (cl_code != sdmr_pkg::CL_2) && (cl_code != sdmr_pkg::CL_3);
  assign o_test_mode        = mode_reg[sdmr_pkg::TM_LSB +: 2] != sdmr_pkg::TM_NORMAL;
  assign o_single_write     = mode_reg[sdmr_pkg::WB_POS];
  assign o_refresh_pulse    = rpulse_reg;
  assign o_refresh_row      = row_reg;
  assign o_self_refresh     = (pwr_reg == sdmr_pkg::SDMR_SREF);
  assign o_power_down       = (pwr_reg == sdmr_pkg::SDMR_PDOWN);
  assign o_clk_suspend      = (pwr_reg == sdmr_pkg::SDMR_SUSPEND);
  assign o_banks_active     = bank_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_rd_word_cl2;
    (valid_reg && !wr_reg && run && cl_code == sdmr_pkg::CL_2) ##1 run;
  endsequence
  sequence s_rd_word_cl3;
    (valid_reg && !wr_reg && run && cl_code == sdmr_pkg::CL_3) ##1 run [*2];
  endsequence

  mrs_load_a: assert property (sel && cmd == sdmr_pkg::CMD_MRS && bank_reg == 4'h0 && !valid_reg
    |=> mode_reg == $past({i_bs, i_addr})) else $error("mode register not loaded");
  cl2_data_a: assert property (s_rd_word_cl2 |=> o_rd_drive)
    else $error("read data late at latency two");
  cl3_data_a: assert property (s_rd_word_cl3 |=> o_rd_drive)
    else $error("read data late at latency three");
  seq_step_a: assert property (adv && !sel && (!o_interleave || page)
    |=> o_col_addr == $past(o_col_addr) + 8'h01) else $error("sequential column wrong");
  ilv_step_a: assert property (adv && !sel && o_interleave && !page
    |=> (o_col_addr ^ start_reg) == (k_reg & imask)) else $error("interleaved column wrong");
  ilv_two_a: assert property (adv && !sel && o_interleave && bl_code == sdmr_pkg::BL_2
    |=> o_col_addr == ($past(start_reg) ^ 8'h01)) else $error("length two interleave wrong");
  page_run_a: assert property (adv && page && !sel |=> o_col_valid)
    else $error("full page burst ended");
  stop_end_a: assert property (sel && cmd == sdmr_pkg::CMD_STOP && !ap_reg |=> !o_col_valid)
    else $error("burst stop ignored");
  stop_ap_a: assert property (sel && cmd == sdmr_pkg::CMD_STOP && ap_reg && adv |=> o_col_valid)
    else $error("burst stop honoured with auto precharge");
  single_wr_a: assert property (sel && cmd == sdmr_pkg::CMD_WRITE && o_single_write && i_cke
    |=> o_col_valid ##1 (!o_col_valid || $past(sel && cmd != sdmr_pkg::CMD_IDLE)))
    else $error("single write ran past one word");
  idle_cmd_a: assert property (sel && cmd == sdmr_pkg::CMD_IDLE && !valid_reg
    |=> $stable(mode_reg) && $stable(bank_reg) && !o_col_valid) else $error("idle command acted");
  deselect_a: assert property (run && i_cs_n && !valid_reg
    |=> $stable(mode_reg) && $stable(bank_reg) && $stable(row_reg)) else $error("deselect acted");
  refresh_a: assert property (sel && cmd == sdmr_pkg::CMD_REF && i_cke
    |=> o_refresh_pulse && o_refresh_row == $past(o_refresh_row) + 12'h001)
    else $error("refresh counter not advanced");
  sref_hold_a: assert property (o_self_refresh && !i_cke |=> o_self_refresh && $stable(mode_reg))
    else $error("self refresh left with gate low");
  // the word taken with the gate low still advances, the one after it is held
  suspend_a: assert property (run && valid_reg && !last && !i_cke && (i_cs_n || cmd == sdmr_pkg::CMD_IDLE)
    |=> o_clk_suspend && o_col_valid ##1 $stable(o_col_addr) && o_col_valid) else $error("burst not frozen");
  pdown_a: assert property (run && !i_cke && !valid_reg && pipe_reg == 3'h0 && bank_reg == 4'h0
    && i_cs_n |=> o_power_down) else $error("power-down not entered");
  resume_a: assert property (!run && i_cke |=> run)
    else $error("clock gate high did not resume");
endmodule

// >>> hw/sdmr_pkg.sv
// mode register field layout, command codes and reset values
package sdmr_pkg;
  localparam int          MODE_W        = 14;
  localparam logic [13:0] MODE_RESET    = 14'h0000;
  localparam int          BL_LSB        = 0;
  localparam int          BT_POS        = 3;
  localparam int          CL_LSB        = 4;
  localparam int          TM_LSB        = 7;
  localparam int          WB_POS        = 9;
  localparam int          AP_POS        = 10;
  localparam logic [2:0]  BL_1          = 3'h0;
  localparam logic [2:0]  BL_2          = 3'h1;
  localparam logic [2:0]  BL_4          = 3'h2;
  localparam logic [2:0]  BL_8          = 3'h3;
  localparam logic [2:0]  BL_PAGE       = 3'h7;
  localparam logic [2:0]  CL_2          = 3'h2;
  localparam logic [2:0]  CL_3          = 3'h3;
  localparam logic [1:0]  TM_NORMAL     = 2'h0;
  // {ras_n, cas_n, we_n}
  localparam logic [2:0]  CMD_IDLE      = 3'h7;
  localparam logic [2:0]  CMD_STOP      = 3'h6;
  localparam logic [2:0]  CMD_READ      = 3'h5;
  localparam logic [2:0]  CMD_WRITE     = 3'h4;
  localparam logic [2:0]  CMD_ACT       = 3'h3;
  localparam logic [2:0]  CMD_PRE       = 3'h2;
  localparam logic [2:0]  CMD_REF       = 3'h1;
  localparam logic [2:0]  CMD_MRS       = 3'h0;
  localparam int          REFRESH_ROWS  = 4096;
  localparam logic [11:0] REF_ROW_RESET = 12'h000;
  localparam logic [7:0]  COL_RESET     = 8'h00;
  localparam logic [2:0]  PIPE_RESET    = 3'h0;
  localparam logic [3:0]  BANK_RESET    = 4'h0;

  typedef enum logic [1:0] {
    SDMR_RUN     = 2'b00,
    SDMR_SUSPEND = 2'b01,
    SDMR_PDOWN   = 2'b10,
    SDMR_SREF    = 2'b11
  } sdmr_pwr_t;
endpackage
